// file: csp_consts.svh
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

`define CSP_ADDR_W 16
`define CSP_ADDR_CKS 16'hff14
`define CSP_ADDR_CTRL 16'hff58
`define CSP_ADDR_MODE 16'hff59
`define CSP_ADDR_HS 16'hff5a
`define CSP_ADDR_DLO 16'hff5b
`define CSP_ADDR_DHI 16'hff5c

`define CSP_BIT_PORT_EN 0
`define CSP_BIT_TRIG 1
`define CSP_BIT_OUT_EN 2
`define CSP_BIT_MASTER 0
`define CSP_BIT_MSB 1
`define CSP_BIT_HS_EN 0
`define CSP_BIT_HS_DIR 1
`define CSP_FMT_PHASE_BIT 0
`define CSP_FMT_POL_BIT 1

`define CSP_SRC_OFF 3'h0
`define CSP_SRC_SLOW1 3'h1
`define CSP_SRC_SLOW2 3'h2
`define CSP_SRC_SLOW4 3'h3
`define CSP_SRC_TIMER 3'h4
`define CSP_SRC_FAST1 3'h5
`define CSP_SRC_FAST2 3'h6
`define CSP_SRC_FAST4 3'h7

`define CSP_LAST_BIT 3'h7
`define CSP_RDATA_RESET 4'h0

`endif

// file: csp_pkg.sv
package csp_pkg;

  typedef enum logic {
    CSP_IDLE,
    CSP_RUN
  } csp_state_type;

  typedef struct packed {
    logic port_en;
    logic out_en;
    logic master;
    logic msb_first;
    logic [1:0] fmt;
    logic hs_en;
    logic hs_dir;
    logic [2:0] src;
  } csp_ctrl_type;

  typedef struct packed {
    logic clock;
    logic tx;
    logic rx;
    logic handshake;
  } csp_pin_own_type;

endpackage

// file: csp_serial_port.sv
`timescale 1ns/1ps
`include "csp_consts.svh"

module csp_serial_port import csp_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [`CSP_ADDR_W-1:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // Clock source ticks from the clock manager
  input wire logic osc1_tick,
  input wire logic osc3_tick,
  input wire logic timer_underflow,
  // Serial clock pin
  input wire logic clock_port_pin_in,
  output logic clock_port_pin_out,
  output logic clock_port_pin_oe,
  // Data pins
  output logic serial_tx_pin_out,
  output logic serial_tx_pin_oe,
  input wire logic serial_rx_pin_in,
  // Handshake pin
  input wire logic handshake_port_pin_in,
  output logic handshake_port_pin_out,
  output logic handshake_port_pin_oe,
  // Pin ownership for the port mux
  output csp_pin_own_type pin_own
);

  csp_ctrl_type ctrl;
  csp_state_type state;
  logic [7:0] sr;
  logic txd;
  logic sclk;
  logic slave_ready;
  logic [2:0] bit_cnt;
  logic [1:0] pre;
  logic [2:0] clk_sync;
  logic [1:0] rx_sync;
  logic [1:0] ss_sync;
  logic [3:0] next_rdata;
  logic running;
  logic pol;
  logic phase;
  logic idle_level;
  logic ss_mode;
  logic rdy_mode;
  logic selected;
  logic src_tick;
  logic [1:0] div_max;
  logic half_evt;
  logic m_tog;
  logic rise;
  logic fall;
  logic active;
  logic ev_a;
  logic ev_b;
  logic ev_sample;
  logic trigger;
  logic data_wr;
  logic data_access;

  function automatic logic out_bit(input logic [7:0] d, input logic msb);
    out_bit = msb ? d[7] : d[0];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                          input logic msb);
    shift_in = msb ? {d[6:0], b} : {b, d[7:1]};
  endfunction

  assign running = (state == CSP_RUN);
  assign pol = ctrl.fmt[`CSP_FMT_POL_BIT];
  assign phase = ctrl.fmt[`CSP_FMT_PHASE_BIT];
  // Idle level chosen so the first edge of a frame is never the output-change edge
  assign idle_level = ~pol;
  assign ss_mode = ~ctrl.master & ctrl.hs_en & ~ctrl.hs_dir;
  assign rdy_mode = ~ctrl.master & ctrl.hs_en & ctrl.hs_dir;
  assign selected = ~ss_mode | ~ss_sync[1];
  assign trigger = reg_wr && (reg_addr == `CSP_ADDR_CTRL) && reg_wdata[`CSP_BIT_TRIG];
  assign data_wr = reg_wr && ((reg_addr == `CSP_ADDR_DLO) || (reg_addr == `CSP_ADDR_DHI));
  assign data_access = data_wr
    || (reg_rd && ((reg_addr == `CSP_ADDR_DLO) || (reg_addr == `CSP_ADDR_DHI)));

  // Control registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `CSP_ADDR_CTRL: begin
          ctrl.port_en <= reg_wdata[`CSP_BIT_PORT_EN];
          ctrl.out_en <= reg_wdata[`CSP_BIT_OUT_EN];
        end
        `CSP_ADDR_MODE: begin
          ctrl.master <= reg_wdata[`CSP_BIT_MASTER];
          ctrl.msb_first <= reg_wdata[`CSP_BIT_MSB];
          ctrl.fmt <= reg_wdata[3:2];
        end
        `CSP_ADDR_HS: begin
          ctrl.hs_en <= reg_wdata[`CSP_BIT_HS_EN];
          ctrl.hs_dir <= reg_wdata[`CSP_BIT_HS_DIR];
        end
        `CSP_ADDR_CKS: begin
          ctrl.src <= reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Pin synchronisers; only the second stage and later are read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // Preset to the reset clock level so no false edge follows reset
      clk_sync <= 3'h7;
      rx_sync <= 2'h0;
      ss_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[1:0], clock_port_pin_in};
      rx_sync <= {rx_sync[0], serial_rx_pin_in};
      ss_sync <= {ss_sync[0], handshake_port_pin_in};
    end
  end

  always_comb begin
    src_tick = 1'b0;
    div_max = 2'h0;
    case (ctrl.src)
      `CSP_SRC_SLOW1: src_tick = osc1_tick;
      `CSP_SRC_SLOW2: begin
        src_tick = osc1_tick;
        div_max = 2'h1;
      end
      `CSP_SRC_SLOW4: begin
        src_tick = osc1_tick;
        div_max = 2'h3;
      end
      // each underflow is a half period, so the clock is underflow / 2
      `CSP_SRC_TIMER: src_tick = timer_underflow;
      `CSP_SRC_FAST1: src_tick = osc3_tick;
      `CSP_SRC_FAST2: begin
        src_tick = osc3_tick;
        div_max = 2'h1;
      end
      `CSP_SRC_FAST4: begin
        src_tick = osc3_tick;
        div_max = 2'h3;
      end
      default: src_tick = 1'b0;
    endcase
  end

  assign half_evt = src_tick && (pre == div_max);

  always_ff @(posedge clk_sys) begin
    if (srst || !running) begin
      pre <= 2'h0;
    end else if (src_tick) begin
      pre <= (pre == div_max) ? 2'h0 : pre + 2'h1;
    end
  end

  // master generates the clock, slave watches the pin
  assign m_tog = ctrl.master && running && ctrl.port_en && half_evt;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclk <= 1'b1;
    end else if (!running) begin
      sclk <= idle_level;
    end else if (m_tog) begin
      sclk <= ~sclk;
    end
  end

  assign rise = ctrl.master ? (m_tog & ~sclk) : (clk_sync[1] & ~clk_sync[2]);
  assign fall = ctrl.master ? (m_tog & sclk) : (~clk_sync[1] & clk_sync[2]);

  // a deselected slave sees no edges
  assign active = running && selected && ctrl.port_en;

  // output changes on rise (positive) or fall (negative)
  assign ev_a = active && (pol ? fall : rise);
  assign ev_b = active && (pol ? rise : fall);
  // sampling edge picked by the phase bit
  assign ev_sample = phase ? ev_b : ev_a;

  // Data register is not reset: contents are undefined until written or received
  always_ff @(posedge clk_sys) begin
    if (data_wr && !running) begin
      // nibble writes build the transmit byte
      if (reg_addr == `CSP_ADDR_DLO) begin
        sr[3:0] <= reg_wdata;
      end else begin
        sr[7:4] <= reg_wdata;
      end
    end else if (ev_sample) begin
      // shift in the received bit in the chosen order
      sr <= shift_in(sr, rx_sync[1], ctrl.msb_first);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txd <= 1'b0;
    end else if (!running) begin
      txd <= out_bit(sr, ctrl.msb_first);
    end else if (ev_a) begin
      // next bit onto the line at the output-change edge
      txd <= phase ? out_bit(sr, ctrl.msb_first)
                   : out_bit(shift_in(sr, rx_sync[1], ctrl.msb_first), ctrl.msb_first);
    end
  end

  // run status from trigger to the eighth clock cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= CSP_IDLE;
      bit_cnt <= 3'h0;
    end else begin
      unique case (state)
        CSP_IDLE: begin
          if (trigger) begin
            state <= CSP_RUN;
            bit_cnt <= 3'h0;
          end else if (data_access) begin
            bit_cnt <= 3'h0;
          end
        end
        CSP_RUN: begin
          if (ev_a) begin
            if (bit_cnt == `CSP_LAST_BIT) begin
              state <= CSP_IDLE;
              bit_cnt <= 3'h0;
            end else begin
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // ready rises on trigger and falls at the first clock edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slave_ready <= 1'b0;
    end else if (trigger && rdy_mode && !running) begin
      slave_ready <= 1'b1;
    end else if (!running || ev_a || ev_b) begin
      slave_ready <= 1'b0;
    end
  end

  // Read path; reserved bits read as zero
  always_comb begin
    next_rdata = 4'h0;
    case (reg_addr)
      `CSP_ADDR_CTRL: next_rdata = {1'b0, ctrl.out_en, running, ctrl.port_en};
      `CSP_ADDR_MODE: next_rdata = {ctrl.fmt, ctrl.msb_first, ctrl.master};
      `CSP_ADDR_HS: next_rdata = {2'h0, ctrl.hs_dir, ctrl.hs_en};
      `CSP_ADDR_DLO: next_rdata = sr[3:0];
      `CSP_ADDR_DHI: next_rdata = sr[7:4];
      `CSP_ADDR_CKS: next_rdata = {1'b0, ctrl.src};
      default: next_rdata = 4'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= `CSP_RDATA_RESET;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : `CSP_RDATA_RESET;
    end
  end

  // clock pin driven only in master mode
  assign clock_port_pin_out = sclk;
  assign clock_port_pin_oe = ctrl.port_en & ctrl.master;
  // transmit drive needs enable and, with select in use, selection
  assign serial_tx_pin_out = txd;
  assign serial_tx_pin_oe = ctrl.port_en & ctrl.out_en & selected;
  // handshake function only in slave mode
  assign handshake_port_pin_out = slave_ready;
  assign handshake_port_pin_oe = ctrl.port_en & rdy_mode;
  // clock and rx ownership follow the port enable; tx also needs out_en, handshake needs hs_en and slave mode
  assign pin_own.clock = ctrl.port_en;
  assign pin_own.tx = ctrl.port_en & ctrl.out_en;
  assign pin_own.rx = ctrl.port_en;
  assign pin_own.handshake = ctrl.port_en & ctrl.hs_en & ~ctrl.master;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_trigger_idle;
    trigger && !running;
  endsequence

  sequence s_last_edge;
    running && ev_a && (bit_cnt == `CSP_LAST_BIT);
  endsequence

  a_trigger_starts_run: assert property (
    s_trigger_idle |=> running ##0 (bit_cnt == 3'h0))
    else $error("trigger did not start a transfer");

  a_zero_write_inert: assert property (
    (reg_wr && reg_addr == `CSP_ADDR_CTRL && !reg_wdata[`CSP_BIT_TRIG] && !running)
      |=> !running)
    else $error("writing zero to trigger started a transfer");

  a_run_ends_eight: assert property (
    s_last_edge |=> !running)
    else $error("run status not cleared after eighth cycle");

  a_status_readback: assert property (
    (reg_rd && reg_addr == `CSP_ADDR_CTRL) |=> reg_rdata[`CSP_BIT_TRIG] == $past(running))
    else $error("run status read back wrong");

  a_port_off_io: assert property (
    !ctrl.port_en |-> (pin_own == '0) && !clock_port_pin_oe && !serial_tx_pin_oe)
    else $error("pins claimed while port disabled");

  a_tx_gate_off: assert property (
    !ctrl.out_en |-> !serial_tx_pin_oe)
    else $error("transmit pin driven while disabled");

  a_clock_dir: assert property (
    clock_port_pin_oe == (ctrl.port_en && ctrl.master))
    else $error("clock pin direction wrong for mode");

  a_idle_clock_level: assert property (
    (!running && $stable(ctrl.fmt) && $past(!running)) |-> clock_port_pin_out == ~pol)
    else $error("idle clock level wrong for polarity");

  a_shift_order: assert property (
    (ev_sample && !data_wr && ctrl.msb_first) |=> sr[0] == $past(rx_sync[1]))
    else $error("msb-first shift did not take rx bit into bit 0");

  a_lsb_shift: assert property (
    (ev_sample && !data_wr && !ctrl.msb_first) |=> sr[7] == $past(rx_sync[1]))
    else $error("lsb-first shift did not take rx bit into bit 7");

  a_ready_rise: assert property (
    (s_trigger_idle and rdy_mode) |=> handshake_port_pin_out)
    else $error("ready not raised after trigger");

  a_select_no_drive: assert property (
    ss_mode |-> !handshake_port_pin_oe)
    else $error("handshake pin driven while used as select input");

  a_master_hs_io: assert property (
    ctrl.master |-> !pin_own.handshake && !handshake_port_pin_oe)
    else $error("handshake pin used in master mode");

  a_ready_drop: assert property (
    (slave_ready && (ev_a || ev_b)) |=> !slave_ready)
    else $error("ready not dropped at first clock edge");

  a_deselect_ignore: assert property (
    (ss_mode && ss_sync[1]) |-> !ev_a && !ev_b && !serial_tx_pin_oe)
    else $error("deselected slave reacted to clock");

endmodule

// file: csp_far_model.sv
`timescale 1ns/1ps

module csp_far_model #(
  parameter int HALF = 10
) (
  // Clock
  input wire logic clk_sys,
  // Frame setup
  input wire logic arm,
  input wire logic go,
  input wire logic [1:0] fmt,
  input wire logic msb,
  input wire logic [7:0] send_byte,
  // Serial lines
  input wire logic sclk_w,
  input wire logic tx_w,
  output logic sclk_drv,
  output logic rx_drv,
  output logic [7:0] got_byte
);
  int scount;
  logic ev_a;

  initial begin
    sclk_drv = 1'b1;
    rx_drv = 1'b0;
    got_byte = 8'h00;
    scount = 0;
  end

  always @(posedge arm) begin
    scount = 0;
    sclk_drv <= ~fmt[1];
    rx_drv <= msb ? send_byte[7] : send_byte[0];
  end

  always @(sclk_w) begin
    if (arm) begin
      ev_a = (sclk_w === ~fmt[1]);
      if (!ev_a) got_byte = msb ? {got_byte[6:0], tx_w} : {tx_w, got_byte[7:1]};
      // Data moves only away from the sampling edge, so it is never caught mid-change
      if (ev_a ^ fmt[0]) scount = scount + 1;
      else if (scount < 8) rx_drv <= msb ? send_byte[7 - scount] : send_byte[scount];
    end
  end

  always @(posedge go) begin
    repeat (16) begin
      repeat (HALF) @(posedge clk_sys);
      sclk_drv <= ~sclk_drv;
    end
  end
endmodule

// file: test_clocked_serial_port_8bit.sv
`timescale 1ns/1ps
`include "csp_consts.svh"

module test_clocked_serial_port_8bit import csp_pkg::*;;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [3:0] reg_wdata = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic osc1_tick = 1'b0;
  logic osc3_tick = 1'b0;
  logic timer_underflow = 1'b0;
  logic hs_in = 1'b1;
  logic arm = 1'b0;
  logic go = 1'b0;
  logic msb = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] got_byte;
  logic [3:0] reg_rdata;
  logic sclk_drv, rx_drv, clk_out, clk_oe, tx_out, tx_oe, hs_out, hs_oe, sclk_w, tx_w;
  csp_pin_own_type pin_own;
  int error_cnt = 0;
  int checks_done = 0;
  int tick_n = 0;
  int hp [8] = '{0, 12, 24, 48, 10, 4, 8, 16};

  assign sclk_w = clk_oe ? clk_out : sclk_drv;
  // An undriven line shows the inverse so a stale value cannot pass
  assign tx_w = tx_oe ? tx_out : ~tx_out;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    tick_n <= tick_n + 1;
    osc3_tick <= (tick_n % 4 == 3);
    osc1_tick <= (tick_n % 12 == 11);
    timer_underflow <= (tick_n % 10 == 9);
    if (tick_n == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  csp_serial_port dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc1_tick(osc1_tick),
    .osc3_tick(osc3_tick), .timer_underflow(timer_underflow), .clock_port_pin_in(sclk_w),
    .clock_port_pin_out(clk_out), .clock_port_pin_oe(clk_oe), .serial_tx_pin_out(tx_out),
    .serial_tx_pin_oe(tx_oe), .serial_rx_pin_in(rx_drv), .handshake_port_pin_in(hs_in),
    .handshake_port_pin_out(hs_out), .handshake_port_pin_oe(hs_oe), .pin_own(pin_own)
  );

  csp_far_model partner (
    .clk_sys(clk_sys), .arm(arm), .go(go), .fmt(fmt), .msb(msb), .send_byte(send_byte),
    .sclk_w(sclk_w), .tx_w(tx_w), .sclk_drv(sclk_drv), .rx_drv(rx_drv), .got_byte(got_byte)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_idle(output int dur);
    logic [3:0] d;
    dur = 0;
    do begin
      rd(`CSP_ADDR_CTRL, d);
      dur += 2;
    end while (d[1] !== 1'b0 && dur < 2000);
  endtask

  task automatic t_regs();
    logic [3:0] d;
    logic [15:0] a [5] = '{`CSP_ADDR_CKS, `CSP_ADDR_CTRL, `CSP_ADDR_MODE, `CSP_ADDR_HS, 16'hff5d};
    foreach (a[i]) begin
      rd(a[i], d);
      chk("reset value", d, 8'h00);
    end
    wr(`CSP_ADDR_HS, 4'hf);
    rd(`CSP_ADDR_HS, d);
    chk("hs bits", d, 8'h03);
    wr(`CSP_ADDR_HS, 4'h0);
    wr(`CSP_ADDR_MODE, 4'hf);
    rd(`CSP_ADDR_MODE, d);
    chk("mode bits", d, 8'h0f);
    $display("test regs done");
  endtask

  task automatic t_pins();
    wr(`CSP_ADDR_MODE, 4'h1);
    wr(`CSP_ADDR_HS, 4'h1);
    wr(`CSP_ADDR_CTRL, 4'h1);
    #1 chk("clock own", pin_own.clock, 8'h01);
    chk("clock drive", clk_oe, 8'h01);
    chk("tx off", tx_oe, 8'h00);
    chk("hs master", {pin_own.handshake, hs_oe}, 8'h00);
    chk("rx own", {pin_own.rx, pin_own.tx}, 8'h02);
    wr(`CSP_ADDR_CTRL, 4'h0);
    #1 chk("released", {pin_own.clock, clk_oe}, 8'h00);
    chk("rx released", pin_own.rx, 8'h00);
    wr(`CSP_ADDR_HS, 4'h0);
    $display("test pins done");
  endtask

  task automatic xfer_master(input logic [1:0] f, input logic m, input logic [2:0] src,
                             input logic [7:0] tb, input logic [7:0] rb, input int h);
    logic [3:0] lo, hi;
    int dur;
    fmt <= f;
    msb <= m;
    send_byte <= rb;
    wr(`CSP_ADDR_CKS, {1'b0, src});
    wr(`CSP_ADDR_MODE, {f, m, 1'b1});
    wr(`CSP_ADDR_DLO, tb[3:0]);
    wr(`CSP_ADDR_DHI, tb[7:4]);
    wr(`CSP_ADDR_CTRL, 4'h5);
    rd(`CSP_ADDR_CTRL, lo);
    chk("trigger zero", lo, 8'h05);
    chk("tx drive", tx_oe, 8'h01);
    arm <= 1'b1;
    wr(`CSP_ADDR_CTRL, 4'h7);
    rd(`CSP_ADDR_CTRL, lo);
    chk("run status", lo, 8'h07);
    chk("clock drive", clk_oe, 8'h01);
    wait_idle(dur);
    arm <= 1'b0;
    chk("tx byte", got_byte, tb);
    rd(`CSP_ADDR_DLO, lo);
    rd(`CSP_ADDR_DHI, hi);
    chk("rx byte", {hi, lo}, rb);
    if (h > 0) chk("duration", (dur >= 14 * h && dur <= 17 * h + 8), 8'h01);
    $display("test master fmt %0d msb %0d src %0d done", f, m, src);
  endtask

  task automatic xfer_slave(input logic [3:0] hs, input logic sel_hi);
    logic [3:0] lo, hi;
    int dur;
    fmt <= 2'h1;
    msb <= 1'b1;
    send_byte <= 8'h5a;
    wr(`CSP_ADDR_CKS, 4'h0);
    wr(`CSP_ADDR_MODE, 4'h6);
    wr(`CSP_ADDR_HS, hs);
    wr(`CSP_ADDR_DLO, 4'h3);
    wr(`CSP_ADDR_DHI, 4'hc);
    wr(`CSP_ADDR_CTRL, 4'h5);
    hs_in <= sel_hi;
    arm <= 1'b1;
    wr(`CSP_ADDR_CTRL, 4'h7);
    @(posedge clk_sys);
    #1 chk("hs drive", hs_oe, {7'h00, hs == 4'h3});
    if (hs == 4'h3) chk("ready high", hs_out, 8'h01);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (14) @(posedge clk_sys);
    if (hs == 4'h3) chk("ready low", hs_out, 8'h00);
    repeat (170) @(posedge clk_sys);
    if (sel_hi) begin
      rd(`CSP_ADDR_CTRL, lo);
      chk("deselected run", lo, 8'h07);
      chk("deselected tx", tx_oe, 8'h00);
      arm <= 1'b0;
      hs_in <= 1'b0;
      @(posedge clk_sys);
      arm <= 1'b1;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
    end
    wait_idle(dur);
    arm <= 1'b0;
    chk("slave tx", got_byte, 8'hc3);
    rd(`CSP_ADDR_DLO, lo);
    rd(`CSP_ADDR_DHI, hi);
    chk("slave rx", {hi, lo}, 8'h5a);
    $display("test slave hs %0d done", hs);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_pins();
    for (int i = 0; i < 8; i++) begin
      xfer_master(i[1:0], i[2], 3'h5, 8'h96 ^ i[7:0], 8'h3c + i[7:0], 0);
    end
    for (int s = 1; s < 8; s++) begin
      xfer_master(2'h0, 1'b0, s[2:0], 8'ha1, 8'h4e, hp[s]);
    end
    xfer_slave(4'h0, 1'b0);
    xfer_slave(4'h3, 1'b0);
    xfer_slave(4'h1, 1'b1);
    test_done();
  end
endmodule
